// ===== sim/display_timing_mode_decoder_bench.sv
// Self-checking bench of the timing sequencer and mode decoder.
// Assumes the decoder assertions live in the design files.
`timescale 1ns/100ps

module display_timing_mode_decoder_bench;
  logic ref_clk = 0, reset_n = 0, internal_resequence_request = 0;
  logic fetch_inhibit = 0, go = 0, slow = 0, op_seen = 0;
  logic analog_clock_10mhz, display_clock_5mhz, sequence_start_flag;
  logic sequence_clock_gate, strobe_phase, register_load_phase;
  logic increment_phase, final_phase, control_word_flag, word_flag;
  logic jump_target_expected, fetch_request, operation_start;
  logic processor_hung, fetched_word_arrived_n;
  logic [3:0] phase_counter, selected_mode_code;
  logic [2:0] control_mode, data_mode, cc [4];
  logic [15:0] mode_onehot, display_program_counter, bus_data, word, pc0;
  int failures = 0, cmp_count = 0, c;

  dtm_decoder i_dtm_decoder (.ref_clk, .reset_n, .fetched_word_arrived_n,
    .internal_resequence_request, .bus_data, .fetch_inhibit,
    .analog_clock_10mhz, .display_clock_5mhz, .sequence_start_flag,
    .sequence_clock_gate, .phase_counter, .strobe_phase,
    .register_load_phase, .increment_phase, .final_phase, .control_mode,
    .data_mode, .control_word_flag, .word_flag, .jump_target_expected,
    .selected_mode_code, .mode_onehot, .display_program_counter,
    .fetch_request, .operation_start, .processor_hung);
  dtm_bus_partner i_dtm_bus_partner (.ref_clk, .go, .slow, .word,
    .final_phase, .arrival_n(fetched_word_arrived_n), .bus_data);

  // Clock of 25 ns period.
  always #12.5 ref_clk = ~ref_clk;

  // ----
  // Shared tasks
  // ----
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One whole sequence, from a fetched word or from a restart.
  task automatic run(input logic [15:0] w, input logic rs);
    int n, t_i, t_f, t_l;
    logic seen_s, seen_g;
    logic [3:0] cnt0;
    seen_s = 0;
    seen_g = 0;
    op_seen = 0;
    t_i = 0;
    t_f = 0;
    t_l = 0;
    cnt0 = 4'hf;
    word = w;
    if (rs)
      internal_resequence_request = 1'b1;
    else
      go = 1'b1;
    tick(2);
    go = 1'b0;
    internal_resequence_request = 1'b0;
    for (n = 1; n < 200 && t_f == 0; n++)
    begin
      tick(1);
      if (sequence_start_flag === 1'b1 && !seen_g) cnt0 = phase_counter;
      if (sequence_start_flag === 1'b1) seen_g = 1'b1;
      if (strobe_phase === 1'b1) seen_s = 1'b1;
      if (register_load_phase === 1'b1) t_l = n;
      if (increment_phase === 1'b1) t_i = n;
      if (operation_start === 1'b1) op_seen = 1'b1;
      if (final_phase === 1'b1) t_f = n;
    end
    check(16'(seen_g), 16'h0001);
    check(16'(cnt0), 16'h0000);
    check(16'(seen_s), 16'(!rs));
    check(16'(t_l != 0), 16'(!rs));
    check(16'(t_f - t_i), 16'h0008);
    check(16'({sequence_start_flag, sequence_clock_gate}), 16'h0000);
    tick(2);
  endtask

  // Watchdog against a hung sequence.
  initial
  begin
    #150000;
    failures++;
    final_report;
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    cc = '{3'h0, 3'h5, 3'h6, 3'h7};
    tick(6);
    reset_n = 1'b1;
    tick(4);
    check(16'({phase_counter, control_mode, data_mode, control_word_flag,
      word_flag, sequence_start_flag, sequence_clock_gate}), 16'h0000);
    check(mode_onehot, 16'h0001);
    pc0 = 16'({analog_clock_10mhz, display_clock_5mhz});
    tick(4);
    check(16'({analog_clock_10mhz, display_clock_5mhz}), pc0 ^ 16'h0001);
    tick(2);
    check(16'(analog_clock_10mhz), 16'(!pc0[1]));
    for (c = 0; c < 7; c++)
    begin
      slow = (c == 3);
      run({2'b10, c[2:0], 11'h000}, 1'b0);
      check(16'({control_mode, data_mode, control_word_flag, word_flag,
        fetch_request}), 16'({3'h0, c[2:0], 3'b101}));
      run(16'h0123, 1'b0);
      check(16'({control_word_flag, word_flag, op_seen, fetch_request}),
        16'h0006);
      check(16'(selected_mode_code), 16'(c));
      check(mode_onehot, 16'h0001 << c);
    end
    slow = 1'b0;
    for (c = 0; c < 4; c++)
    begin
      pc0 = display_program_counter;
      run({2'b11, cc[c], 11'h000}, 1'b0);
      check(16'({control_mode, data_mode, fetch_request}),
        16'({cc[c], 3'h6, 1'b1}));
      check(mode_onehot, 16'h0100 << cc[c]);
      check(display_program_counter, pc0 + 16'h0002);
    end
    run(16'he000, 1'b0);
    check(16'(jump_target_expected), 16'h0001);
    run(16'h0400, 1'b0);
    check(display_program_counter, 16'h0400);
    check(16'({control_mode, data_mode, control_word_flag}),
      16'({3'h4, 3'h6, 1'b1}));
    fetch_inhibit = 1'b1;
    run(16'he800, 1'b0);
    check(16'(fetch_request), 16'h0000);
    fetch_inhibit = 1'b0;
    pc0 = display_program_counter;
    run(16'h0000, 1'b1);
    check(16'(fetch_request), 16'h0001);
    check(display_program_counter, pc0 + 16'h0002);
    run(16'hc800, 1'b0);
    check(16'(processor_hung), 16'h0001);
    final_report;
  end
endmodule // display_timing_mode_decoder_bench

// ===== sim/dtm_bus_partner.sv
// Bus side model: presents one fetched word per request from the bench.
// Assumes the decoder takes the word on the falling arrival line.
`timescale 1ns/100ps

module dtm_bus_partner
(
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [15:0] word,
  input  wire logic        final_phase,
  output logic             arrival_n,
  output logic [15:0]      bus_data
);
  // ----
  // Memory answer
  // ----
  // The word is driven in the same step as arrival falls and is held until the final
  // phase. After release the lines show the inverse, never a stale word.
  initial
  begin
    arrival_n = 1'b1;
    bus_data = 16'h0000;
    forever
    begin
      @(posedge ref_clk);
      if (go === 1'b1)
      begin
        if (slow === 1'b1)
          repeat (5) @(posedge ref_clk);
        #1 bus_data = word;
        arrival_n = 1'b0;
        do
          @(posedge ref_clk);
        while (final_phase !== 1'b1);
        #1 arrival_n = 1'b1;
        bus_data = ~bus_data;
      end
    end
  end
endmodule // dtm_bus_partner

// ===== src/dtm_decoder.sv
// Timing sequencer and mode decoder of a vector display processor.
// Assumes the fetched-word arrival, restart and bus data come from
// outside this clock domain; fetch_inhibit comes from logic on ref_clk.
//
// Behaviour
// RL1: Arrival or restart sets start flag, enables gate.
// RL2: Four one-clock phases: strobe, load, increment, final.
// RL3: Strobe phase captures bus word for decoding.
// RL4: Load phase loads mode registers, clears fetch request.
// RL5: Final phase requests fetch or starts decoded operation.
// RL6: Final phase clears start flag, sequencer goes idle.
// RL7: Restart sequences skip strobe and load phases.
// RL8: Derive 10 MHz and 5 MHz clocks by halving.
// RL9: Phase counter cleared before each sequence starts.
// RL10: Bit 15 set means instruction, else data.
// RL11: Bit 14 set means control, else graphic instruction.
// RL12: Control instruction loads control mode register only.
// RL13: Graphic instruction loads data mode, control zero.
// RL14: No mode register clocking while jump executes.
// RL15: Graphic codes: char, vectors, point, graphs, relpoint.
// RL16: Control codes: jump, no-op, status A, status B.
// RL17: Control code zero asserts graphic mode, fetches.
// RL18: Program never presents spare codes; they hang.
// RL19: Instruction strobe clears word flag, sets control flag.
// RL20: Data word clears control flag; flag selects register.
// RL21: Jump address word leaves control flag untouched.
// RL22: Four-bit mode code decodes to one output.
// RL23: Data words select data mode, instructions control.
// RL24: Reset: idle, counter, mode registers, flags cleared.
`timescale 1ns/100ps
`include "dtm_params.svh"
module dtm_decoder
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     fetched_word_arrived_n,
  input  wire logic                     internal_resequence_request,
  input  wire logic [`DTM_WORD_W-1:0]   bus_data,
  input  wire logic                     fetch_inhibit,
  output logic                          analog_clock_10mhz,
  output logic                          display_clock_5mhz,
  output logic                          sequence_start_flag,
  output logic                          sequence_clock_gate,
  output logic [`DTM_CNT_W-1:0]         phase_counter,
  output logic                          strobe_phase,
  output logic                          register_load_phase,
  output logic                          increment_phase,
  output logic                          final_phase,
  output logic [`DTM_MODE_W-1:0]        control_mode,
  output logic [`DTM_MODE_W-1:0]        data_mode,
  output logic                          control_word_flag,
  output logic                          word_flag,
  output logic                          jump_target_expected,
  output logic [`DTM_CODE_W-1:0]        selected_mode_code,
  output logic [15:0]                   mode_onehot,
  output logic [`DTM_WORD_W-1:0]        display_program_counter,
  output logic                          fetch_request,
  output logic                          operation_start,
  output logic                          processor_hung
);

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n_sync;

  // Reset asserts at once but leaves on the clock, so no flop of the
  // state record sees a release close to an edge.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // -------------------------------------------------------------------
  // State record
  // -------------------------------------------------------------------
  dtm_pkg::dtm_state_t  st_reg;
  dtm_pkg::dtm_state_t  st_next;

  // Next state: synchronisers, divider, sequencer and decoder in one.
  always_comb
  begin
    logic                    en5;
    logic                    arrive;
    logic                    restart;
    logic [`DTM_MODE_W-1:0]  field;
    logic                    spare;
    en5     = (st_reg.div == `DTM_DIV_LAST);
    arrive  = st_reg.arr_prev && !st_reg.arr_s2;
    restart = st_reg.rsq_s2 && !st_reg.rsq_prev;
    field   = st_reg.captured[`DTM_FIELD_HI:`DTM_FIELD_LO];
    spare   = st_reg.cont_flag
              ? (st_reg.ctrl_mode >= `DTM_CM_SPARE_LO &&
                 st_reg.ctrl_mode <= `DTM_CM_SPARE_HI)
              : (st_reg.data_mode == `DTM_GM_SPARE);
    st_next = st_reg;

    // Pin inputs pass two stages; edges compare the second stage with a delayed copy.
    st_next.arr_s1   = fetched_word_arrived_n;
    st_next.arr_s2   = st_reg.arr_s1;
    st_next.arr_prev = st_reg.arr_s2;
    st_next.rsq_s1   = internal_resequence_request;
    st_next.rsq_s2   = st_reg.rsq_s1;
    st_next.rsq_prev = st_reg.rsq_s2;
    st_next.bus_s1   = bus_data;
    st_next.bus_s2   = st_reg.bus_s1;

    // The 40 MHz clock stands in for the 20 MHz crystal; divider bits
    // give the halved clocks, and the wrap is the display clock enable.
    st_next.div   = st_reg.div + `DTM_DIV_STEP;                 // [RL8]
    st_next.clk10 = st_next.div[1];                            // [RL8]
    st_next.clk5  = st_next.div[2];                            // [RL8]

    // Phase pulses last one ref_clk cycle.
    st_next.strobe   = 1'b0;
    st_next.load     = 1'b0;
    st_next.incr     = 1'b0;
    st_next.final_ph = 1'b0;
    st_next.op_start = 1'b0;

    case (st_reg.seq)
      dtm_pkg::DTM_SEQ_IDLE:
      begin
        // A hung processor ignores further triggers until reset.
        if ((arrive || restart) && !st_reg.hung)
        begin
          st_next.seq          = dtm_pkg::DTM_SEQ_ARMED;        // [RL1]
          st_next.phase_cnt    = `DTM_CNT_RST;                  // [RL9]
          st_next.from_restart = !arrive;                       // [RL7]
        end
      end
      dtm_pkg::DTM_SEQ_ARMED:
      begin
        // The gate opens on a display clock edge, like a primed J-K.
        if (en5)
        begin
          st_next.seq = dtm_pkg::DTM_SEQ_RUN;                   // [RL1]
        end
      end
      dtm_pkg::DTM_SEQ_RUN:
      begin
        if (en5)
        begin
          st_next.phase_cnt = st_reg.phase_cnt + `DTM_PH_STEP;  // [RL2]
          case (st_reg.phase_cnt[2:0])
            `DTM_PH_STROBE:
            begin
              if (!st_reg.from_restart)                         // [RL7]
              begin
                st_next.strobe   = 1'b1;                        // [RL2]
                st_next.captured = st_reg.bus_s2;               // [RL3]
                if (st_reg.jump_exp)
                begin
                  // Address word: the flags keep their state.  [RL21]
                  st_next.cont_flag = st_reg.cont_flag;
                end
                else if (st_reg.bus_s2[`DTM_BIT_INSTR])         // [RL10]
                begin
                  st_next.word_flag = 1'b0;                     // [RL19]
                  st_next.cont_flag = 1'b1;                     // [RL19]
                end
                else
                begin
                  // Data words alternate the word flag (X then Y).
                  st_next.cont_flag = 1'b0;                     // [RL20]
                  st_next.word_flag = !st_reg.word_flag;
                end
              end
            end
            `DTM_PH_LOAD:
            begin
              if (!st_reg.from_restart)                         // [RL7]
              begin
                st_next.load      = 1'b1;                       // [RL2]
                st_next.fetch_req = 1'b0;                       // [RL4]
                if (st_reg.jump_exp)
                begin
                  // Jump target: mode registers stay as they are.
                  st_next.pc       = st_reg.captured;           // [RL14]
                  st_next.jmp_word = 1'b1;
                  st_next.jump_exp = 1'b0;
                end
                else if (st_reg.captured[`DTM_BIT_INSTR])       // [RL10]
                begin
                  if (st_reg.captured[`DTM_BIT_CTRL])           // [RL11]
                  begin
                    st_next.ctrl_mode = field;                  // [RL12]
                    st_next.jump_exp  = (field == `DTM_CM_JUMP); // [RL16]
                  end
                  else
                  begin
                    st_next.data_mode = field;                  // [RL13]
                    st_next.ctrl_mode = `DTM_CM_SETGRAPH;       // [RL13]
                  end
                end
              end
            end
            `DTM_PH_INCR:
            begin
              st_next.incr = 1'b1;                              // [RL2]
              // A loaded jump target is itself the next address.
              if (!st_reg.jmp_word)
              begin
                st_next.pc = st_reg.pc + `DTM_PC_STEP;          // [RL2]
              end
            end
            `DTM_PH_FINAL:
            begin
              st_next.final_ph = 1'b1;                          // [RL2]
              st_next.seq      = dtm_pkg::DTM_SEQ_IDLE;         // [RL6]
              st_next.jmp_word = 1'b0;
              if (spare && !st_reg.from_restart)
              begin
                // Spare codes stall everything, as the hardware did.
                st_next.hung = 1'b1;                            // [RL18]
              end
              else if (!st_reg.cont_flag && !st_reg.from_restart &&
                       !st_reg.jmp_word)
              begin
                st_next.op_start = 1'b1;                        // [RL5]
              end
              else if (!fetch_inhibit)
              begin
                st_next.fetch_req = 1'b1;                       // [RL5] [RL17]
              end
            end
            default:
            begin
              st_next.seq = dtm_pkg::DTM_SEQ_IDLE;
            end
          endcase
        end
      end
      default:
      begin
        st_next.seq = dtm_pkg::DTM_SEQ_IDLE;
      end
    endcase

    // Mode selector and one-of-sixteen decode, from the new registers.
    st_next.mode_code = {st_next.cont_flag,                     // [RL22]
                         st_next.cont_flag ? st_next.ctrl_mode  // [RL23]
                                           : st_next.data_mode};
    st_next.onehot    = `DTM_ONEHOT_BASE << st_next.mode_code; // [RL22] [RL15]
  end

  // Register the whole record; reset leaves every flag clear.
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      st_reg           <= '0;                                   // [RL24]
      st_reg.arr_s1    <= 1'b1;
      st_reg.arr_s2    <= 1'b1;
      st_reg.arr_prev  <= 1'b1;
      st_reg.seq       <= dtm_pkg::DTM_SEQ_IDLE;                // [RL24]
      st_reg.ctrl_mode <= `DTM_MODE_RST;                        // [RL24]
      st_reg.data_mode <= `DTM_MODE_RST;                        // [RL24]
      st_reg.pc        <= `DTM_PC_RST;
      st_reg.onehot    <= `DTM_ONEHOT_BASE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs, each a field of the registered record
  // -------------------------------------------------------------------
  assign analog_clock_10mhz      = st_reg.clk10;
  assign display_clock_5mhz      = st_reg.clk5;
  assign sequence_start_flag     = st_reg.seq[0];
  assign sequence_clock_gate     = st_reg.seq[1];
  assign phase_counter           = st_reg.phase_cnt;
  assign strobe_phase            = st_reg.strobe;
  assign register_load_phase     = st_reg.load;
  assign increment_phase         = st_reg.incr;
  assign final_phase             = st_reg.final_ph;
  assign control_mode            = st_reg.ctrl_mode;
  assign data_mode               = st_reg.data_mode;
  assign control_word_flag       = st_reg.cont_flag;
  assign word_flag               = st_reg.word_flag;
  assign jump_target_expected    = st_reg.jump_exp;
  assign selected_mode_code      = st_reg.mode_code;
  assign mode_onehot             = st_reg.onehot;
  assign display_program_counter = st_reg.pc;
  assign fetch_request           = st_reg.fetch_req;
  assign operation_start         = st_reg.op_start;
  assign processor_hung          = st_reg.hung;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_sync);

  strobe_to_load_a: assert property ( // [RL2]
    st_reg.strobe |-> ##8 st_reg.load)
    else $error("load phase did not follow strobe by eight cycles");

  incr_to_final_a: assert property ( // [RL2]
    st_reg.incr |-> ##8 (st_reg.final_ph && !st_reg.incr))
    else $error("final phase did not follow increment phase");

  final_goes_idle_a: assert property ( // [RL6]
    st_reg.final_ph |-> (st_reg.seq == dtm_pkg::DTM_SEQ_IDLE))
    else $error("sequencer not idle after final phase");

  restart_no_strobe_a: assert property ( // [RL7]
    (st_reg.strobe || st_reg.load) |-> !st_reg.from_restart)
    else $error("restart sequence produced strobe or load");

  arm_clears_count_a: assert property ( // [RL9]
    $rose(st_reg.seq[0]) |-> (st_reg.phase_cnt == `DTM_CNT_RST))
    else $error("phase counter not cleared at sequence start");

  ctrl_load_a: assert property ( // [RL12]
    (st_reg.load && $past(st_reg.captured[15:14]) == 2'b11 &&
     !$past(st_reg.jump_exp))
    |-> (st_reg.ctrl_mode == $past(st_reg.captured[13:11]) &&
         $stable(st_reg.data_mode)))
    else $error("control instruction loaded wrong mode register");

  gfx_load_a: assert property ( // [RL13]
    (st_reg.load && $past(st_reg.captured[15:14]) == 2'b10 &&
     !$past(st_reg.jump_exp))
    |-> (st_reg.ctrl_mode == `DTM_CM_SETGRAPH &&
         st_reg.data_mode == $past(st_reg.captured[13:11])))
    else $error("graphic instruction loaded wrong mode value");

  jump_hold_a: assert property ( // [RL14]
    (st_reg.load && $past(st_reg.jump_exp))
    |-> ($stable(st_reg.ctrl_mode) && $stable(st_reg.data_mode) &&
         st_reg.pc == $past(st_reg.captured)))
    else $error("mode registers changed on jump target word");

  mode_select_a: assert property ( // [RL22]
    $onehot(st_reg.onehot) &&
    st_reg.onehot[st_reg.mode_code] &&
    st_reg.mode_code[3] == st_reg.cont_flag)
    else $error("mode decode not one-hot or code mismatch");

  load_clears_req_a: assert property ( // [RL4]
    st_reg.load |-> !st_reg.fetch_req)
    else $error("fetch request survived load phase");

  final_outcome_a: assert property ( // [RL5]
    (st_reg.final_ph && !$past(fetch_inhibit))
    |=> (st_reg.fetch_req || $past(st_reg.op_start) || st_reg.hung))
    else $error("final phase neither fetched nor started operation");

  display_clock_a: assert property ( // [RL8]
    $rose(st_reg.clk5) |-> ##4 $fell(st_reg.clk5))
    else $error("display clock half period is not four cycles");

  full_seq_c: cover property (
    st_reg.strobe ##8 st_reg.load ##8 st_reg.incr ##8 st_reg.final_ph);
  restart_seq_c: cover property (
    st_reg.from_restart && st_reg.final_ph);
  jump_word_c: cover property (st_reg.load && $past(st_reg.jump_exp));
  op_start_c: cover property (st_reg.op_start);

endmodule // dtm_decoder

// ===== src/dtm_params.svh
// Constants of the display timing and mode decoder: word fields, mode
// codes, phase numbers, reset values and clock ratios.
// Assumes it is included by the package and by the decoder module.
`ifndef DTM_PARAMS_SVH
`define DTM_PARAMS_SVH

// ---------------------------------------------------------------------
// Clock rates and derived divider counts
// ---------------------------------------------------------------------
`define DTM_REF_CLK_HZ    40000000
`define DTM_XTAL_HZ       20000000
`define DTM_ANALOG_HZ     10000000
`define DTM_DISPLAY_HZ    5000000
`define DTM_DIV_W         3
`define DTM_DIV_LAST      3'((`DTM_REF_CLK_HZ / `DTM_DISPLAY_HZ) - 1)
`define DTM_DIV_STEP      3'h1

// ---------------------------------------------------------------------
// Fetched word layout
// ---------------------------------------------------------------------
`define DTM_WORD_W        16
`define DTM_BIT_INSTR     15
`define DTM_BIT_CTRL      14
`define DTM_FIELD_HI      13
`define DTM_FIELD_LO      11
`define DTM_MODE_W        3
`define DTM_CODE_W        4

// ---------------------------------------------------------------------
// Graphic mode codes (data mode register)
// ---------------------------------------------------------------------
`define DTM_GM_CHAR       3'h0
`define DTM_GM_SVECT      3'h1
`define DTM_GM_LVECT      3'h2
`define DTM_GM_POINT      3'h3
`define DTM_GM_GRAPHX     3'h4
`define DTM_GM_GRAPHY     3'h5
`define DTM_GM_RELPT      3'h6
`define DTM_GM_SPARE      3'h7

// ---------------------------------------------------------------------
// Control mode codes (control mode register)
// ---------------------------------------------------------------------
`define DTM_CM_SETGRAPH   3'h0
`define DTM_CM_SPARE_LO   3'h1
`define DTM_CM_SPARE_HI   3'h3
`define DTM_CM_JUMP       3'h4
`define DTM_CM_NOOP       3'h5
`define DTM_CM_STATA      3'h6
`define DTM_CM_STATB      3'h7

// ---------------------------------------------------------------------
// Phase counter decode and reset values
// ---------------------------------------------------------------------
`define DTM_PH_STROBE     3'h0
`define DTM_PH_LOAD       3'h1
`define DTM_PH_INCR       3'h2
`define DTM_PH_FINAL      3'h3
`define DTM_PH_STEP       4'h1
`define DTM_CNT_W         4
`define DTM_CNT_RST       4'h0
`define DTM_MODE_RST      3'h0
`define DTM_PC_RST        16'h0000
`define DTM_PC_STEP       16'h0002
`define DTM_ONEHOT_BASE   16'h0001

`endif

// ===== src/dtm_pkg.sv
// Types of the display timing and mode decoder: sequencer states and the
// packed state record of the decoder.
// Assumes dtm_params.svh sits beside it on the include path.
`include "dtm_params.svh"

package dtm_pkg;

  // -------------------------------------------------------------------
  // Sequencer states; bit 0 is the start flag, bit 1 the clock gate.
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    DTM_SEQ_IDLE  = 2'b00,
    DTM_SEQ_ARMED = 2'b01,
    DTM_SEQ_RUN   = 2'b11
  } dtm_seq_t;

  // -------------------------------------------------------------------
  // Whole state of the decoder, registered as one record.
  // -------------------------------------------------------------------
  typedef struct packed {
    logic                     arr_s1;
    logic                     arr_s2;
    logic                     arr_prev;
    logic                     rsq_s1;
    logic                     rsq_s2;
    logic                     rsq_prev;
    logic [`DTM_WORD_W-1:0]   bus_s1;
    logic [`DTM_WORD_W-1:0]   bus_s2;
    logic [`DTM_DIV_W-1:0]    div;
    logic                     clk10;
    logic                     clk5;
    dtm_seq_t                 seq;
    logic                     from_restart;
    logic [`DTM_CNT_W-1:0]    phase_cnt;
    logic                     strobe;
    logic                     load;
    logic                     incr;
    logic                     final_ph;
    logic [`DTM_WORD_W-1:0]   captured;
    logic [`DTM_MODE_W-1:0]   ctrl_mode;
    logic [`DTM_MODE_W-1:0]   data_mode;
    logic                     cont_flag;
    logic                     word_flag;
    logic                     jump_exp;
    logic                     jmp_word;
    logic [`DTM_WORD_W-1:0]   pc;
    logic                     fetch_req;
    logic                     op_start;
    logic                     hung;
    logic [`DTM_CODE_W-1:0]   mode_code;
    logic [15:0]              onehot;
  } dtm_state_t;

endpackage
